// ### logic/sscd_regs.sv
// sim slot control, debounce and timing clock select register bank
`timescale 1ns/1ps
module sscd_regs #(
  parameter int INT_TICK_CYCLES = sscd_pkg::TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // register port of the serial interface
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // timing clock pin
  input wire logic ext_clk_in,
  // detection inputs
  input wire logic battery_presence_input_in,
  input wire logic shutdown_request_input_in,
  // baseband-side card signals, shared by both slots
  input wire logic [sscd_pkg::CARD_SIGS-1:0] bb_sig_in,
  // slot one
  output logic slot_one_supply_on_out,
  output logic slot_one_supply_high_out,
  output logic slot_one_supply_pulldown_out,
  output logic slot_one_drive_out,
  output logic slot_one_pulldown_out,
  output logic [sscd_pkg::CARD_SIGS-1:0] slot_one_sig_out,
  output logic [1:0] slot_one_status_out,
  // slot two
  output logic slot_two_supply_on_out,
  output logic slot_two_supply_high_out,
  output logic slot_two_supply_pulldown_out,
  output logic slot_two_drive_out,
  output logic slot_two_pulldown_out,
  output logic [sscd_pkg::CARD_SIGS-1:0] slot_two_sig_out,
  output logic [1:0] slot_two_status_out,
  // detection results and timing tick
  output logic battery_absent_out,
  output logic shutdown_level_out,
  output logic timing_tick_out
);
  import sscd_pkg::*;

  localparam logic [12:0] TICK_LAST = 13'(INT_TICK_CYCLES - 1);

  // ---- registers ----
  logic [7:0] slot_ctrl_ff, nxt_slot_ctrl;
  logic [7:0] bat_cnt_ff, nxt_bat_cnt;
  logic [7:0] sdn_cnt_ff, nxt_sdn_cnt;
  logic clk_sel_ff, nxt_clk_sel;
  logic [7:0] rdata_ff, nxt_rdata;
  logic bat_wr, sdn_wr;
  logic [7:0] status_val;

  assign bat_wr = reg_wr_in && reg_addr_in == BAT_DEB_ADDR;
  assign sdn_wr = reg_wr_in && reg_addr_in == SDN_DEB_ADDR;

  // whole-byte writes; state and regulator bits are just separate stored bits
  always_comb begin
    nxt_slot_ctrl = slot_ctrl_ff;
    nxt_bat_cnt = bat_cnt_ff;
    nxt_sdn_cnt = sdn_cnt_ff;
    nxt_clk_sel = clk_sel_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr_in && reg_addr_in == SLOT_CTRL_ADDR) begin
      nxt_slot_ctrl = reg_wdata_in; // RL6 RL8
    end
    if (bat_wr) begin
      nxt_bat_cnt = reg_wdata_in; // RL10
    end
    if (sdn_wr) begin
      nxt_sdn_cnt = reg_wdata_in; // RL11
    end
    if (reg_wr_in && reg_addr_in == CLK_CTRL_ADDR) begin
      nxt_clk_sel = reg_wdata_in[CLK_SEL_BIT]; // RL14
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        STATUS_ADDR: nxt_rdata = status_val;
        SLOT_CTRL_ADDR: nxt_rdata = slot_ctrl_ff;
        BAT_DEB_ADDR: nxt_rdata = bat_cnt_ff;
        SDN_DEB_ADDR: nxt_rdata = sdn_cnt_ff;
        CLK_CTRL_ADDR: nxt_rdata = {clk_sel_ff, 7'h00}; // RL14
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slot_ctrl_ff <= SLOT_CTRL_RST;
      bat_cnt_ff <= DEB_COUNT_RST; // RL15
      sdn_cnt_ff <= DEB_COUNT_RST; // RL15
      clk_sel_ff <= CLK_CTRL_RST[CLK_SEL_BIT];
      rdata_ff <= 8'h00;
    end else if (ce_in) begin
      slot_ctrl_ff <= nxt_slot_ctrl;
      bat_cnt_ff <= nxt_bat_cnt;
      sdn_cnt_ff <= nxt_sdn_cnt;
      clk_sel_ff <= nxt_clk_sel;
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata_out = rdata_ff;

  // ---- timing clock: internal divider or external pin, switched on tick boundaries ----
  sscd_clk_state_type cs_ff, nxt_cs;
  logic [12:0] div_ff, nxt_div;
  logic ext_prev_ff, nxt_ext_prev;
  logic int_tick, ext_tick, tick;

  assign int_tick = (div_ff == TICK_LAST);
  assign ext_tick = ext_clk_in && !ext_prev_ff;

  // the old source finishes its period, then the first new edge only arms the new source
  always_comb begin
    nxt_div = int_tick ? 13'h0000 : div_ff + 13'h0001;
    nxt_ext_prev = ext_clk_in;
    nxt_cs = cs_ff;
    tick = 1'b0;
    case (cs_ff)
      CS_INT: begin
        tick = int_tick;
        if (clk_sel_ff && int_tick) begin
          nxt_cs = CS_TO_EXT; // RL18
        end
      end
      CS_TO_EXT: begin
        if (ext_tick) begin
          nxt_cs = CS_EXT; // RL18
        end
      end
      CS_EXT: begin
        tick = ext_tick;
        if (!clk_sel_ff && ext_tick) begin
          nxt_cs = CS_TO_INT; // RL18
        end
      end
      CS_TO_INT: begin
        if (int_tick) begin
          nxt_cs = CS_INT; // RL18
        end
      end
      default: nxt_cs = CS_INT;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_ff <= CS_INT;
      div_ff <= 13'h0000;
      ext_prev_ff <= 1'b0;
    end else if (ce_in) begin
      cs_ff <= nxt_cs;
      div_ff <= nxt_div;
      ext_prev_ff <= nxt_ext_prev;
    end
  end
  assign timing_tick_out = tick;

  // ---- debounce filters ----
  logic bat_level, sdn_level, bat_expired;

  sscd_debounce u_bat_deb (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .limit_in(bat_cnt_ff),
    .reload_in(bat_wr), // RL12
    .raw_in(battery_presence_input_in),
    .level_out(bat_level),
    .expired_out(bat_expired)
  );

  sscd_debounce u_sdn_deb (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .limit_in(sdn_cnt_ff),
    .reload_in(sdn_wr), // RL12
    .raw_in(shutdown_request_input_in),
    .level_out(sdn_level),
    .expired_out()
  );

  // a high debounced comparator level means the pack has gone
  assign battery_absent_out = bat_level; // RL16
  assign shutdown_level_out = sdn_level;

  // ---- slot decode and card-side drivers ----
  logic [1:0] st1, st2;
  logic [1:0] stat1, stat2;
  logic [CARD_SIGS-1:0] sig1_ff, nxt_sig1, sig2_ff, nxt_sig2;

  assign st1 = slot_ctrl_ff[STATE_LSB+1:STATE_LSB];
  assign st2 = slot_ctrl_ff[STATE_LSB+SLOT_STRIDE+1:STATE_LSB+SLOT_STRIDE];
  assign stat1 = slot_status(st1, slot_ctrl_ff[REG_ON_BIT]); // RL9
  assign stat2 = slot_status(st2, slot_ctrl_ff[REG_ON_BIT+SLOT_STRIDE]); // RL9

  // interrupt bits are not kept here and read as zero
  always_comb begin
    status_val = 8'h00;
    status_val[STAT_SDN_BIT] = sdn_level;
    status_val[STAT_BAT_BIT] = bat_level; // RL16
    status_val[STAT_SLOT_LSB+1:STAT_SLOT_LSB] = stat1;
    status_val[STAT_SLOT_LSB+STAT_SLOT_STRIDE+1:STAT_SLOT_LSB+STAT_SLOT_STRIDE] = stat2;
  end

  // isolated keeps the last level; anything not active or isolated drives low
  always_comb begin
    nxt_sig1 = (stat1 == ST_ACT) ? bb_sig_in : (stat1 == ST_ISO) ? sig1_ff : '0; // RL3 RL4 RL5
    nxt_sig2 = (stat2 == ST_ACT) ? bb_sig_in : (stat2 == ST_ISO) ? sig2_ff : '0; // RL3 RL4 RL5
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sig1_ff <= '0;
      sig2_ff <= '0;
    end else if (ce_in) begin
      sig1_ff <= nxt_sig1;
      sig2_ff <= nxt_sig2;
    end
  end

  assign slot_one_supply_on_out = slot_ctrl_ff[REG_ON_BIT]; // RL1
  assign slot_one_supply_pulldown_out = !slot_ctrl_ff[REG_ON_BIT]; // RL1
  assign slot_one_supply_high_out = slot_ctrl_ff[VSEL_BIT]; // RL2
  assign slot_one_drive_out = (stat1 != ST_DOWN); // RL3
  assign slot_one_pulldown_out = (stat1 == ST_DOWN) || (st1 == ST_PWR); // RL3 RL7
  assign slot_one_sig_out = sig1_ff;
  assign slot_one_status_out = stat1;
  assign slot_two_supply_on_out = slot_ctrl_ff[REG_ON_BIT+SLOT_STRIDE]; // RL1
  assign slot_two_supply_pulldown_out = !slot_ctrl_ff[REG_ON_BIT+SLOT_STRIDE]; // RL1
  assign slot_two_supply_high_out = slot_ctrl_ff[VSEL_BIT+SLOT_STRIDE]; // RL2
  assign slot_two_drive_out = (stat2 != ST_DOWN); // RL3
  assign slot_two_pulldown_out = (stat2 == ST_DOWN) || (st2 == ST_PWR); // RL3 RL7
  assign slot_two_sig_out = sig2_ff;
  assign slot_two_status_out = stat2;

  // ---- checks ----
  property p_status_map;
    @(posedge clock_in) disable iff (!rst_b_in)
      !slot_ctrl_ff[REG_ON_BIT] |-> (slot_one_status_out == ST_DOWN && !slot_one_drive_out);
  endproperty
  a_status_map: assert property (p_status_map) else $error("slot one not down with regulator off"); // RL9

  property p_state10;
    @(posedge clock_in) disable iff (!rst_b_in)
      (st2 == ST_PWR && slot_ctrl_ff[REG_ON_BIT+SLOT_STRIDE]) |->
        (slot_two_status_out == ST_PWR && slot_two_pulldown_out && slot_two_drive_out);
  endproperty
  a_state10: assert property (p_state10) else $error("state 10 not powered with pull-downs"); // RL7

  property p_follow;
    @(posedge clock_in) disable iff (!rst_b_in)
      (ce_in && slot_one_status_out == ST_ACT) |=> (slot_one_sig_out == $past(bb_sig_in));
  endproperty
  a_follow: assert property (p_follow) else $error("active slot does not follow baseband"); // RL5

  property p_hold;
    @(posedge clock_in) disable iff (!rst_b_in)
      (ce_in && slot_two_status_out == ST_ISO) |=> $stable(slot_two_sig_out);
  endproperty
  a_hold: assert property (p_hold) else $error("isolated slot outputs moved"); // RL4

  property p_state_write_keeps_reg;
    @(posedge clock_in) disable iff (!rst_b_in)
      (ce_in && reg_wr_in && reg_addr_in == SLOT_CTRL_ADDR) |=>
        (slot_one_supply_on_out == $past(reg_wdata_in[REG_ON_BIT]) &&
         slot_two_supply_high_out == $past(reg_wdata_in[VSEL_BIT+SLOT_STRIDE]));
  endproperty
  a_state_write_keeps_reg: assert property (p_state_write_keeps_reg) else $error("slot control write lost"); // RL8

  property p_no_tick_switching;
    @(posedge clock_in) disable iff (!rst_b_in)
      (cs_ff == CS_TO_EXT || cs_ff == CS_TO_INT) |-> !timing_tick_out;
  endproperty
  a_no_tick_switching: assert property (p_no_tick_switching) else $error("tick during source change"); // RL18

  property p_reserved_zero;
    @(posedge clock_in) disable iff (!rst_b_in)
      (ce_in && reg_rd_in && reg_addr_in == CLK_CTRL_ADDR) |=> (reg_rdata_out[6:0] == 7'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved clock bits not zero"); // RL14

  property p_bat_expiry;
    @(posedge clock_in) disable iff (!rst_b_in)
      ($past(ce_in) && bat_expired) |->
        (battery_absent_out == $past(battery_presence_input_in) && status_val[STAT_BAT_BIT] == battery_absent_out);
  endproperty
  a_bat_expiry: assert property (p_bat_expiry) else $error("battery status not from filter"); // RL16

  c_active: cover property (@(posedge clock_in) disable iff (!rst_b_in) slot_one_status_out == ST_ACT);
  c_ext_clk: cover property (@(posedge clock_in) disable iff (!rst_b_in) cs_ff == CS_EXT && timing_tick_out);
  c_bat_gone: cover property (@(posedge clock_in) disable iff (!rst_b_in) $rose(battery_absent_out));
endmodule // sscd_regs

// ### logic/sscd_pkg.sv
// constants, field layout and types for the sim slot control and debounce register bank
// How it works
// [RL1] slot regulator bit 0/4: 0 turns supply off with pull-down, 1 powers it on
// [RL2] slot voltage bit 1/5: 0 selects 1.8 V supply, 1 selects 2.95 V
// [RL3] state 00 is powered down if regulator off, totem-pole low if regulator on
// [RL4] state 01 holds card-side outputs at their last level, totem pole still driving
// [RL5] state 11 makes card-side outputs follow the baseband-side inputs
// [RL6] software must never write 10 to a state field; hardware accepts it anyway
// [RL7] state 10 acts as powered with pull-downs, unlike 00 with regulator on
// [RL8] state fields and regulator bits are stored independently, neither alters the other
// [RL9] reported slot status combines the state field with the regulator bit
// [RL10] battery-presence debounce holds an 8-bit count; 00h passes the input unfiltered
// [RL11] shutdown debounce holds an 8-bit count; 00h bypasses filtering
// [RL12] writing a debounce count while counting restarts that counter with the new count
// [RL13] a new debounce count takes effect within one timing clock period
// [RL14] clock control bit 7 picks internal (0) or external (1) timing clock; 6:0 reserved
// [RL15] debounce counts are in timing clock cycles; reset loads both with four
// [RL16] battery debounce expiry marks the battery as not present in status
// [RL17] counter restarts on any raw input change; level updates after count stable cycles
// [RL18] timing clock source changeover never yields a short or extra tick
package sscd_pkg;
  // register offsets
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] SLOT_CTRL_ADDR = 8'h08;
  localparam logic [7:0] BAT_DEB_ADDR = 8'h0a;
  localparam logic [7:0] SDN_DEB_ADDR = 8'h0b;
  localparam logic [7:0] CLK_CTRL_ADDR = 8'h0d;
  // values after reset
  localparam logic [7:0] SLOT_CTRL_RST = 8'h00;
  localparam logic [7:0] DEB_COUNT_RST = 8'h04;
  localparam logic [7:0] CLK_CTRL_RST = 8'h00;
  // slot control field positions, slot two sits one stride above slot one; then the clock control select bit
  localparam int SLOT_STRIDE = 4;
  localparam int REG_ON_BIT = 0;
  localparam int VSEL_BIT = 1;
  localparam int STATE_LSB = 2;
  localparam int CLK_SEL_BIT = 7;
  // status register field positions
  localparam int STAT_SDN_BIT = 0;
  localparam int STAT_BAT_BIT = 2;
  localparam int STAT_SLOT_LSB = 4;
  localparam int STAT_SLOT_STRIDE = 2;
  // slot state / status codes
  localparam logic [1:0] ST_DOWN = 2'h0;
  localparam logic [1:0] ST_ISO = 2'h1;
  localparam logic [1:0] ST_PWR = 2'h2;
  localparam logic [1:0] ST_ACT = 2'h3;
  // timing clock derived from the system clock, and the card signal count
  localparam int SYS_FREQ_HZ = 200_000_000;
  localparam int TIMING_FREQ_HZ = 32_768;
  localparam int TICK_CYCLES = SYS_FREQ_HZ / TIMING_FREQ_HZ;
  localparam int CARD_SIGS = 3;
  // timing clock source selection, gray along int -> to_ext -> ext -> to_int
  typedef enum logic [1:0] {
    CS_INT = 2'b00,
    CS_TO_EXT = 2'b01,
    CS_EXT = 2'b11,
    CS_TO_INT = 2'b10
  } sscd_clk_state_type;
  // reported status from stored state and regulator bit
  function automatic logic [1:0] slot_status(input logic [1:0] state, input logic reg_on);
    logic [1:0] res;
    res = ST_DOWN;
    if (reg_on) begin
      res = (state == ST_DOWN) ? ST_PWR : state;
    end
    return res;
  endfunction
endpackage

// ### logic/sscd_debounce.sv
// programmable debounce filter counted in timing clock ticks
`timescale 1ns/1ps
module sscd_debounce (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // timing
  input wire logic tick_in,
  // filter control
  input wire logic [7:0] limit_in,
  input wire logic reload_in,
  input wire logic raw_in,
  // result
  output logic level_out,
  output logic expired_out
);
  import sscd_pkg::*;
  logic [7:0] cnt_ff, nxt_cnt;
  logic prev_ff, nxt_prev;
  logic level_ff, nxt_level;
  logic exp_ff, nxt_exp;
  logic running;
  logic [7:0] cnt_inc;

  assign running = (raw_in != level_ff);
  assign cnt_inc = cnt_ff + 8'h01;

  // filter next state; a raw change or a count write wipes progress so far
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_prev = raw_in;
    nxt_level = level_ff;
    nxt_exp = 1'b0;
    if (limit_in == 8'h00) begin
      nxt_level = raw_in; // RL10 RL11
      nxt_cnt = 8'h00;
    end else if (raw_in != prev_ff) begin
      nxt_cnt = 8'h00; // RL17
    end else if (reload_in && running) begin
      nxt_cnt = 8'h00; // RL12 RL13
    end else if (!running) begin
      nxt_cnt = 8'h00;
    end else if (tick_in) begin
      if (cnt_inc >= limit_in) begin
        nxt_level = raw_in; // RL15 RL17
        nxt_exp = 1'b1;
        nxt_cnt = 8'h00;
      end else begin
        nxt_cnt = cnt_inc;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff <= 8'h00;
      prev_ff <= 1'b0;
      level_ff <= 1'b0;
      exp_ff <= 1'b0;
    end else if (ce_in) begin
      cnt_ff <= nxt_cnt;
      prev_ff <= nxt_prev;
      level_ff <= nxt_level;
      exp_ff <= nxt_exp;
    end
  end

  assign level_out = level_ff;
  assign expired_out = exp_ff;

  // with a zero count the output copies the input one cycle later
  property p_bypass;
    @(posedge clock_in) disable iff (!rst_b_in)
      (ce_in && limit_in == 8'h00) |=> (level_out == $past(raw_in));
  endproperty
  a_bypass: assert property (p_bypass) else $error("zero count does not bypass filter"); // RL10

  // an input change never moves the level in the very next cycle while filtering
  property p_change_restart;
    @(posedge clock_in) disable iff (!rst_b_in)
      (ce_in && limit_in != 8'h00 && raw_in != prev_ff) |=> (cnt_ff == 8'h00 && $stable(level_out));
  endproperty
  a_change_restart: assert property (p_change_restart) else $error("raw change did not restart count"); // RL17
endmodule // sscd_debounce

// ### bench/sscd_host.sv
// baseband host model that programs the slot control bank over its register port
`timescale 1ns/1ps
module sscd_host (
  // clock
  input wire logic clock_in,
  // register port
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  import sscd_pkg::*;
  int unsigned gap = 0;
  bit allow_bad_state = 1'b0;
  // idle port at time zero
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // idle cycles first so the host can be prompt or slow; one strobe per byte
  task automatic req(input logic wr, input logic [7:0] a, input logic [7:0] d);
    repeat (gap) @(posedge clock_in);
    @(posedge clock_in);
    reg_wr_out <= wr;
    reg_rd_out <= !wr;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    // released lines carry inverted leftovers so nothing leans on stale values
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  // a state field of 10 only goes out when a scenario asks for it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == SLOT_CTRL_ADDR && !allow_bad_state && (d[3:2] == 2'b10 || d[7:6] == 2'b10)) begin
      return;
    end
    req(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    req(1'b0, a, 8'h00);
  endtask
endmodule // sscd_host

// ### bench/tb_sim_slot_control_debounce_regs.sv
// self-checking bench for the slot control and debounce register bank
`timescale 1ns/1ps
module tb_sim_slot_control_debounce_regs;
  import sscd_pkg::*;
  localparam int TK = 8;
  logic clock_in, rst_b_in, ce_in, ext_clk_in, bat_in, sdn_in, reg_wr, reg_rd, rd_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [CARD_SIGS-1:0] bb_sig, s1_sig, s2_sig;
  logic s1_on, s1_hi, s1_spd, s1_drv, s1_pd, s2_on, s2_hi, s2_spd, s2_drv, s2_pd;
  logic [1:0] s1_st, s2_st;
  logic bat_lvl, sdn_lvl, tick;
  logic [7:0] exp_q[$];
  string name_q[$];
  int fails = 0;
  int cmp_count = 0;
  int gap_c = 0;
  int tick_n = 0;

  sscd_regs #(.INT_TICK_CYCLES(TK)) u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .ext_clk_in(ext_clk_in), .battery_presence_input_in(bat_in),
    .shutdown_request_input_in(sdn_in), .bb_sig_in(bb_sig), .slot_one_supply_on_out(s1_on),
    .slot_one_supply_high_out(s1_hi), .slot_one_supply_pulldown_out(s1_spd), .slot_one_drive_out(s1_drv),
    .slot_one_pulldown_out(s1_pd), .slot_one_sig_out(s1_sig), .slot_one_status_out(s1_st),
    .slot_two_supply_on_out(s2_on), .slot_two_supply_high_out(s2_hi), .slot_two_supply_pulldown_out(s2_spd),
    .slot_two_drive_out(s2_drv), .slot_two_pulldown_out(s2_pd), .slot_two_sig_out(s2_sig),
    .slot_two_status_out(s2_st), .battery_absent_out(bat_lvl), .shutdown_level_out(sdn_lvl),
    .timing_tick_out(tick));
  sscd_host u_host (.clock_in(clock_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata));

  // system clock, and a free-running external timing clock of 40 cycles
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    ext_clk_in = 1'b0;
    forever begin
      repeat (20) @(posedge clock_in);
      ext_clk_in <= ~ext_clk_in;
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // read answers and tick spacing are judged off the edge, where they have settled
  always @(posedge clock_in) rd_d <= reg_rd && ce_in;
  always @(negedge clock_in) begin
    if (rd_d === 1'b1) begin
      check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
    end
    // a frozen tick is only consumed by an enabled edge, so only enabled cycles count
    if (ce_in) gap_c++;
    if (tick === 1'b1 && ce_in) begin
      tick_n++;
      check("tick spacing", 8'(gap_c >= TK), 8'h01);
      gap_c = 0;
    end
  end
  initial begin
    repeat (100000) @(posedge clock_in);
    fails++;
    stop_test();
  end

  task automatic rd_exp(input string nm, input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    u_host.rd(a);
  endtask
  // expected {0, status, supply on, high, supply pulldown, drive, line pulldown} of one slot nibble
  function automatic logic [7:0] slot_exp(input logic [3:0] n);
    logic [1:0] st;
    st = !n[0] ? 2'b00 : (n[3:2] == 2'b00 ? 2'b10 : n[3:2]);
    return {1'b0, st, n[0], n[1], !n[0], st != 2'b00, st == 2'b00 || n[3:2] == 2'b10};
  endfunction
  task automatic sig_case(input int s, input logic [3:0] n, input logic [2:0] b0, input logic [2:0] b1,
                          input logic [2:0] e);
    @(posedge clock_in);
    bb_sig <= b0;
    u_host.wr(SLOT_CTRL_ADDR, s ? {n, 4'h0} : {4'h0, n});
    bb_sig <= b1;
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    check("card lines", {5'h00, s ? s2_sig : s1_sig}, {5'h00, e});
  endtask
  function automatic logic lvl(input int s);
    return s ? sdn_lvl : bat_lvl;
  endfunction
  task automatic raw(input int s, input logic v);
    @(posedge clock_in);
    if (s) sdn_in <= v; else bat_in <= v;
  endtask
  // cycles until the filtered level reaches v, bounded
  task automatic wait_lvl(input int s, input logic v, output int d);
    d = 0;
    while (lvl(s) !== v) begin
      @(negedge clock_in);
      d++;
      if (d > 3000) begin
        fails++;
        stop_test();
      end
    end
  endtask

  initial begin
    logic [7:0] v, e1, e2;
    logic [2:0] a;
    int d;
    void'($urandom(32'h0b8a));
    rst_b_in = 1'b0;
    ce_in = 1'b1;
    bat_in = 1'b0;
    sdn_in = 1'b0;
    bb_sig = 3'h0;
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    // defaults after reset, and an unmapped place
    rd_exp("slot ctrl reset", SLOT_CTRL_ADDR, 8'h00);
    rd_exp("bat count reset", BAT_DEB_ADDR, 8'h04);
    rd_exp("sdn count reset", SDN_DEB_ADDR, 8'h04);
    rd_exp("clk ctrl reset", CLK_CTRL_ADDR, 8'h00);
    rd_exp("unmapped read", 8'h33, 8'h00);
    // every nibble pairing of both slots, state 10 included on purpose
    u_host.allow_bad_state = 1'b1;
    for (int i = 0; i < 256; i++) begin
      v = 8'(i);
      e1 = slot_exp(v[3:0]);
      e2 = slot_exp(v[7:4]);
      u_host.gap = $urandom % 3;
      u_host.wr(SLOT_CTRL_ADDR, v);
      @(negedge clock_in);
      check("slot one pins", {1'b0, s1_st, s1_on, s1_hi, s1_spd, s1_drv, s1_pd}, e1);
      check("slot two pins", {1'b0, s2_st, s2_on, s2_hi, s2_spd, s2_drv, s2_pd}, e2);
      rd_exp("slot ctrl", SLOT_CTRL_ADDR, v);
      rd_exp("slot status", STATUS_ADDR, {e2[6:5], e1[6:5], 4'h0});
    end
    // card lines follow, hold, or are driven low
    for (int s = 0; s < 2; s++) begin
      a = 3'($urandom);
      sig_case(s, 4'hd, a, ~a, ~a);
      sig_case(s, 4'h5, a, ~a, a);
      sig_case(s, 4'h1, a, ~a, 3'h0);
      sig_case(s, 4'h9, a, ~a, 3'h0);
    end
    u_host.allow_bad_state = 1'b0;
    // both filters: delay, glitch, restart on a count write, bypass
    for (int s = 0; s < 2; s++) begin
      u_host.wr(BAT_DEB_ADDR + 8'(s), 8'h03);
      raw(s, 1'b1);
      wait_lvl(s, 1'b1, d);
      check("debounce delay", 8'(d >= 2 * TK && d <= 3 * TK + 3), 8'h01);
      raw(s, 1'b0);
      repeat (TK) @(posedge clock_in);
      raw(s, 1'b1);
      d = 0;
      repeat (5 * TK) begin
        @(negedge clock_in);
        if (lvl(s) !== 1'b1) d = 1;
      end
      check("glitch ignored", 8'(d), 8'h00);
      u_host.wr(BAT_DEB_ADDR + 8'(s), 8'hc8);
      raw(s, 1'b0);
      repeat (6 * TK) @(negedge clock_in);
      check("level held", 8'(lvl(s)), 8'h01);
      u_host.wr(BAT_DEB_ADDR + 8'(s), 8'h02);
      wait_lvl(s, 1'b0, d);
      check("restart delay", 8'(d > TK && d <= 2 * TK), 8'h01);
      u_host.wr(BAT_DEB_ADDR + 8'(s), 8'h00);
      raw(s, 1'b1);
      wait_lvl(s, 1'b1, d);
      check("bypass delay", 8'(d <= 2), 8'h01);
    end
    // slot two was left at state 10 with its regulator on
    rd_exp("status levels", STATUS_ADDR, 8'h85);
    // timing clock source: external, then back to internal
    u_host.wr(CLK_CTRL_ADDR, 8'hff);
    rd_exp("clk ctrl", CLK_CTRL_ADDR, 8'h80);
    repeat (200) @(posedge clock_in);
    tick_n = 0;
    repeat (800) @(posedge clock_in);
    check("external ticks", 8'(tick_n), 8'h14);
    u_host.wr(CLK_CTRL_ADDR, 8'h00);
    repeat (200) @(posedge clock_in);
    tick_n = 0;
    repeat (800) @(posedge clock_in);
    check("internal ticks", 8'(tick_n), 8'h64);
    // writes offered while the clock enable is low must be dropped
    @(posedge clock_in);
    ce_in <= 1'b0;
    u_host.wr(BAT_DEB_ADDR, 8'h5a);
    u_host.wr(SLOT_CTRL_ADDR, 8'h0f);
    @(posedge clock_in);
    ce_in <= 1'b1;
    rd_exp("frozen count", BAT_DEB_ADDR, 8'h00);
    rd_exp("frozen slot ctrl", SLOT_CTRL_ADDR, 8'h90);
    repeat (4) @(posedge clock_in);
    stop_test();
  end
endmodule // tb_sim_slot_control_debounce_regs
